/* File: rtl/lsafmt_pkg.sv */
// formatter package: op codes, classes, states, fault codes, counts.
// assumes every user runs on the single core clock.
package lsafmt_pkg;

    // operation codes presented by the core with each request
    typedef enum logic [2:0] {
        OP_BYTE   = 3'h0,  // byte load or store
        OP_HALF   = 3'h1,  // halfword load or store
        OP_WORD   = 3'h2,  // single word load or store
        OP_SWAP   = 3'h3,  // swap (load or store half of it)
        OP_EXCL   = 3'h4,  // exclusive word access
        OP_DOUBLE = 3'h5,  // two-word transfer
        OP_MULTI  = 3'h6   // multiple-register or coprocessor transfer
    } lsafmt_op_t;

    // access classes, one-hot
    typedef enum logic [6:0] {
        CLS_NONE    = 7'h00,
        CLS_BYTE    = 7'h01,
        CLS_HALF    = 7'h02,
        CLS_SINGLE_WORD_LOAD   = 7'h04,  // single_word_load
        CLS_SINGLE_WORD_STORE  = 7'h08,  // single_word_store
        CLS_WEXCL   = 7'h10,  // exclusive_word_access
        CLS_TWO     = 7'h20,
        CLS_MULTI   = 7'h40
    } lsafmt_class_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ISSUE = 3'h2,
        ST_WAIT  = 3'h4
    } lsafmt_state_t;

    // transfer size seen by the formatters
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } lsafmt_size_t;

    localparam logic [3:0]  FAULT_NONE     = 4'h0;  // status after reset
    localparam logic [3:0]  FAULT_ALIGN    = 4'h1;  // alignment fault code
    localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
    localparam logic [1:0]  WINV_BYTE_XOR  = 2'h3;
    localparam logic [1:0]  WINV_HALF_XOR  = 2'h2;
    localparam logic [4:0]  BEATS_SINGLE   = 5'h01;
    localparam logic [4:0]  BEATS_DOUBLE   = 5'h02;
    localparam logic [4:0]  BEATS_MAX      = 5'h10;  // count code 0 means this
    localparam logic [31:0] ALIGN_MASK     = 32'hffff_fffc;

    // word alignment: clear the two low address bits only
    function automatic logic [31:0] word_align(input logic [31:0] a);
        word_align = a & ALIGN_MASK;
    endfunction

endpackage

/* File: rtl/lsafmt_load_fmt.sv */
// load formatter: memory lanes to register value; caller registers it.
// assumes lane i of the memory word is physical byte offset i.
module lsafmt_load_fmt
    import lsafmt_pkg::*;
(
    input  wire logic [31:0] rdata_i,   // word from memory
    input  wire logic [1:0]  off_i,     // physical byte offset
    input  wire logic [1:0]  size_i,    // byte, half or word
    input  wire logic        sgn_i,     // sign extend
    input  wire logic        swap_i,    // byte-invariant big-endian
    input  wire logic        rot_i,     // legacy word rotate
    output logic      [31:0] data_o     // register value
);
    logic [7:0]  lane [4];   // memory word split into lanes
    logic [31:0] rev;        // byte-reversed word
    logic [63:0] dbl;        // doubled word for rotation
    logic [31:0] rotw;       // rotated word

    // lane split and reversal share one loop
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lane[i] = rdata_i[8*i +: 8];
        assign rev[8*(3-i) +: 8] = rdata_i[8*i +: 8];
    end

    assign dbl  = {rdata_i, rdata_i};
    assign rotw = dbl[8*off_i +: 32];

    always_comb begin
        logic [7:0]  b;
        logic [15:0] h;
        b = lane[off_i];
        h = 16'h0000;
        data_o = 32'h0000_0000;
        case (size_i)
            SZ_BYTE: begin
                data_o = {{24{sgn_i & b[7]}}, b};
            end
            SZ_HALF: begin
                if (swap_i) begin
                    h = {lane[{off_i[1], 1'b0}], lane[{off_i[1], 1'b1}]};
                end else begin
                    h = {lane[{off_i[1], 1'b1}], lane[{off_i[1], 1'b0}]};
                end
                // sign from bit 15, replicate bit 15
                data_o = {{16{sgn_i & h[15]}}, h};
            end
            SZ_WORD: begin
                if (swap_i) begin
                    data_o = rev;
                end else if (rot_i) begin
                    data_o = rotw;
                end else begin
                    data_o = rdata_i;
                end
            end
            default: begin
                data_o = rdata_i;
            end
        endcase
    end
endmodule

/* File: rtl/lsafmt_store_fmt.sv */
// store formatter: register data to lanes and byte enables; combinational.
// assumes lane i of the memory word is physical byte offset i.
module lsafmt_store_fmt
    import lsafmt_pkg::*;
(
    input  wire logic [31:0] src_i,     // register value
    input  wire logic [1:0]  off_i,     // physical byte offset
    input  wire logic [1:0]  size_i,    // byte, half or word
    input  wire logic        swap_i,    // byte-invariant big-endian
    output logic      [31:0] wdata_o,   // lanes to memory
    output logic      [3:0]  be_o       // byte enables
);
    logic [31:0] rev;   // byte-reversed source

    for (genvar i = 0; i < 4; i++) begin : g_rev
        assign rev[8*(3-i) +: 8] = src_i[8*i +: 8];
    end

    always_comb begin
        logic [15:0] h;
        h = swap_i ? {src_i[7:0], src_i[15:8]} : src_i[15:0];
        wdata_o = src_i;
        be_o = 4'hf;
        case (size_i)
            SZ_BYTE: begin
                wdata_o = {4{src_i[7:0]}};
                be_o = 4'h1 << off_i;
            end
            SZ_HALF: begin
                wdata_o = {h, h};
                be_o = off_i[1] ? 4'hc : 4'h3;
            end
            SZ_WORD: begin
                wdata_o = swap_i ? rev : src_i;
                be_o = 4'hf;
            end
            default: begin
                wdata_o = src_i;
                be_o = 4'hf;
            end
        endcase
    end
endmodule

/* File: rtl/lsafmt_top.sv */
// load/store formatter between the register file and data memory.
// assumes same-clock inputs, a one-cycle memory ack per held request and
// a register file that returns the word for SRC_IDX_O in the same cycle.
//
// What this block does
// - unsigned byte load zero fills upper bits
// - signed byte load copies bit 7 upward
// - byte store writes only low byte
// - little-endian half: low address in bits 7:0
// - big-endian half: low address in bits 15:8
// - little-endian signed half extends bit 15
// - big-endian signed half extends bit 15
// - strict check faults odd halfword address
// - little-endian half store: low bits first
// - big-endian half store: high bits first
// - word load byte order follows endianness
// - word store byte order follows endianness
// - block loads become aligned rising word loads
// - block stores become aligned rising word stores
// - strict check faults unaligned block transfers
// - classify every access, swap by unaligned support
// - word-invariant mode flips byte address by three, halfword address by two
// - halfword pairs bytes in endian order
// - word joins four bytes in endian order
// - alignment clears two low address bits
// - later words add four, same endianness
// - data endian flag picks big-endian formatting unless word-invariant mode is on
// - unaligned support and strict check inputs
module lsafmt_top
    import lsafmt_pkg::*;
(
    input  wire logic        REF_CLK_I, // core clock
    input  wire logic        RESET_I, // async, active high
    input  wire logic        DATA_BIG_END_I, // status register data endian flag
    input  wire logic        UNALIGN_EN_I, // control unaligned support
    input  wire logic        STRICT_ALIGN_I, // control strict checking
    input  wire logic        WORD_INV_BE_I, // word_invariant_big_endian
    input  wire logic        REQ_VALID_I, // request strobe
    input  wire logic [2:0]  REQ_OP_I, // operation code
    input  wire logic        REQ_STORE_I, // store when high
    input  wire logic        REQ_SIGNED_I, // sign extend loads
    input  wire logic [31:0] REQ_ADDR_I, // effective address
    input  wire logic [4:0]  REQ_COUNT_I, // words of a multiple
    input  wire logic [31:0] SRC_DATA_I, // store word from regs
    input  wire logic        MEM_ACK_I, // memory beat done
    input  wire logic [31:0] MEM_RDATA_I, // memory read word
    output logic             REQ_READY_O, // idle, may accept
    output logic             MEM_REQ_O, // memory request
    output logic             MEM_WE_O, // memory write
    output logic      [31:0] MEM_ADDR_O, // aligned word address
    output logic      [3:0]  MEM_BE_O, // byte enables
    output logic      [31:0] MEM_WDATA_O, // store lanes
    output logic      [4:0]  SRC_IDX_O, // store word wanted
    output logic             RF_WE_O, // load result strobe
    output logic      [4:0]  RF_IDX_O, // word index of result
    output logic      [31:0] RF_WDATA_O, // load result
    output logic             DONE_O, // transfer finished
    output logic             FAULT_O, // data abort pulse
    output logic      [3:0]  FAULT_STATUS_O, // fault code of last request
    output logic      [6:0]  ACC_CLASS_O // class of last request
);

    // held request fields, frozen for the whole transfer, plus state, word address and beat that advance
    lsafmt_state_t state_reg; // sequencer state
    logic [31:0]   addr_reg; // current word address
    logic [1:0]    off_reg; // physical byte offset
    logic [1:0]    size_reg; // formatter size
    logic          store_reg; // transfer direction
    logic          sgn_reg; // sign extension
    logic          swap_reg; // byte reversal
    logic          rot_reg; // legacy word rotate
    logic [4:0]    beats_reg; // total words
    logic [4:0]    beat_reg; // word in progress

    // decode of the incoming request
    lsafmt_class_t cls_next; // class of the request
    logic [1:0]    size_next; // formatter size
    logic [4:0]    beats_next; // words to move
    logic [1:0]    xor_next; // word-invariant address flip
    logic [31:0]   paddr_next; // physical byte address
    logic          fault_next; // alignment fault decision
    logic          swap_next; // byte-invariant big-endian
    logic          rot_next; // rotate legacy word load

    // formatter results
    logic [31:0]   ld_data; // formatted load value
    logic [31:0]   st_data; // formatted store lanes
    logic [3:0]    st_be; // store byte enables
    logic [1:0]    st_off; // offset used for stores
    logic [1:0]    st_size; // size used for stores
    logic          st_swap; // swap used for stores
    logic          accept; // request taken this cycle
    logic          last_beat; // ack closes the transfer

    assign accept    = (state_reg == ST_IDLE) && REQ_VALID_I;
    assign last_beat = (beat_reg + 5'h01) == beats_reg;

    // classify the access
    // swap counts as exclusive only with unaligned support on
    always_comb begin
        cls_next = CLS_NONE;
        case (lsafmt_op_t'(REQ_OP_I))
            OP_BYTE: begin
                cls_next = CLS_BYTE;
            end
            OP_HALF: begin
                cls_next = CLS_HALF;
            end
            OP_WORD: begin
                cls_next = REQ_STORE_I ? CLS_SINGLE_WORD_STORE : CLS_SINGLE_WORD_LOAD;
            end
            OP_SWAP: begin
                if (UNALIGN_EN_I) begin
                    cls_next = CLS_WEXCL;
                end else begin
                    cls_next = REQ_STORE_I ? CLS_SINGLE_WORD_STORE : CLS_SINGLE_WORD_LOAD;
                end
            end
            OP_EXCL: begin
                cls_next = CLS_WEXCL;
            end
            OP_DOUBLE: begin
                cls_next = CLS_TWO;
            end
            OP_MULTI: begin
                cls_next = CLS_MULTI;
            end
            default: begin
                cls_next = CLS_NONE;
            end
        endcase
    end

    // size and number of words for each class
    always_comb begin
        size_next  = SZ_WORD;
        beats_next = BEATS_SINGLE;
        case (cls_next)
            CLS_BYTE: begin
                size_next = SZ_BYTE;
            end
            CLS_HALF: begin
                size_next = SZ_HALF;
            end
            CLS_TWO: begin
                beats_next = BEATS_DOUBLE;
            end
            CLS_MULTI: begin
                // a zero count stands for a block of 16 words
                beats_next = (REQ_COUNT_I == 5'h00) ? BEATS_MAX : REQ_COUNT_I;
            end
            default: begin
                size_next  = SZ_WORD;
                beats_next = BEATS_SINGLE;
            end
        endcase
    end

    // word-invariant byte address flip
    // that mode becomes little-endian lanes; aligned words are untouched
    always_comb begin
        xor_next = 2'h0;
        if (WORD_INV_BE_I && size_next == SZ_BYTE) begin
            xor_next = WINV_BYTE_XOR;
        end else if (WORD_INV_BE_I && size_next == SZ_HALF) begin
            xor_next = WINV_HALF_XOR;
        end
        paddr_next = {REQ_ADDR_I[31:2], REQ_ADDR_I[1:0] ^ xor_next};
    end

    // data endian flag selects byte reversal unless word-invariant mode is on
    assign swap_next = DATA_BIG_END_I && !WORD_INV_BE_I;
    // legacy single word loads without byte reversal rotate by the byte offset
    assign rot_next  = !UNALIGN_EN_I && (cls_next == CLS_SINGLE_WORD_LOAD);

    // alignment fault decision
    // unaligned support and strict check steer faults
    always_comb begin
        fault_next = 1'b0;
        case (cls_next)
            CLS_HALF: begin
                fault_next = STRICT_ALIGN_I && REQ_ADDR_I[0];
            end
            CLS_SINGLE_WORD_LOAD, CLS_SINGLE_WORD_STORE: begin
                fault_next = STRICT_ALIGN_I && (REQ_ADDR_I[1:0] != 2'h0);
            end
            CLS_WEXCL, CLS_MULTI: begin
                fault_next = (STRICT_ALIGN_I || UNALIGN_EN_I)
                             && (REQ_ADDR_I[1:0] != 2'h0);
            end
            CLS_TWO: begin
                // two-word, 64-bit alignment only under strict check without unaligned support
                fault_next = ((STRICT_ALIGN_I || UNALIGN_EN_I)
                              && (REQ_ADDR_I[1:0] != 2'h0))
                             || (STRICT_ALIGN_I && !UNALIGN_EN_I && REQ_ADDR_I[2]);
            end
            default: begin
                fault_next = 1'b0;
            end
        endcase
    end

    // first store word from the live request, later ones from held fields
    assign st_off  = accept ? paddr_next[1:0] : off_reg;
    assign st_size = accept ? size_next : size_reg;
    assign st_swap = accept ? swap_next : swap_reg;

    lsafmt_load_fmt u_load_fmt (
        .rdata_i (MEM_RDATA_I),
        .off_i   (off_reg),
        .size_i  (size_reg),
        .sgn_i   (sgn_reg),
        .swap_i  (swap_reg),
        .rot_i   (rot_reg),
        .data_o  (ld_data)
    );

    lsafmt_store_fmt u_store_fmt (
        .src_i   (SRC_DATA_I),
        .off_i   (st_off),
        .size_i  (st_size),
        .swap_i  (st_swap),
        .wdata_o (st_data),
        .be_o    (st_be)
    );

    // sequencer: one memory word per beat
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // a faulted request never leaves idle
                    if (accept && !fault_next) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_ISSUE: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (MEM_ACK_I) begin
                        state_reg <= last_beat ? ST_IDLE : ST_ISSUE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // held request fields; a block keeps its starting endianness
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            off_reg   <= 2'h0;
            size_reg  <= SZ_WORD;
            store_reg <= 1'b0;
            sgn_reg   <= 1'b0;
            swap_reg  <= 1'b0;
            rot_reg   <= 1'b0;
            beats_reg <= BEATS_SINGLE;
        end else if (accept) begin
            off_reg   <= paddr_next[1:0];
            size_reg  <= size_next;
            store_reg <= REQ_STORE_I;
            sgn_reg   <= REQ_SIGNED_I;
            swap_reg  <= swap_next;
            rot_reg   <= rot_next;
            beats_reg <= beats_next;
        end
    end

    // word address and beat counting
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            addr_reg  <= 32'h0000_0000;
            beat_reg  <= 5'h00;
            SRC_IDX_O <= 5'h00;
        end else if (accept) begin
            addr_reg  <= word_align(paddr_next);
            beat_reg  <= 5'h00;
            SRC_IDX_O <= 5'h00;
        end else if (state_reg == ST_WAIT && MEM_ACK_I) begin
            if (last_beat) begin
                beat_reg  <= 5'h00;
                SRC_IDX_O <= 5'h00;
            end else begin
                addr_reg  <= addr_reg + WORD_STEP;
                beat_reg  <= beat_reg + 5'h01;
                SRC_IDX_O <= beat_reg + 5'h01;
            end
        end
    end

    // memory request port; request held until acked
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            MEM_REQ_O   <= 1'b0;
            MEM_WE_O    <= 1'b0;
            MEM_ADDR_O  <= 32'h0000_0000;
            MEM_BE_O    <= 4'h0;
            MEM_WDATA_O <= 32'h0000_0000;
        end else if ((accept && !fault_next) || state_reg == ST_ISSUE) begin
            MEM_REQ_O   <= 1'b1;
            MEM_WE_O    <= accept ? REQ_STORE_I : store_reg;
            MEM_ADDR_O  <= accept ? word_align(paddr_next) : addr_reg;
            MEM_BE_O    <= st_be;
            MEM_WDATA_O <= st_data;
        end else if (state_reg == ST_WAIT && MEM_ACK_I) begin
            // drop between words so the next store word can be fetched
            MEM_REQ_O <= 1'b0;
            MEM_WE_O  <= 1'b0;
        end
    end

    // register file result
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RF_WE_O    <= 1'b0;
            RF_IDX_O   <= 5'h00;
            RF_WDATA_O <= 32'h0000_0000;
        end else begin
            RF_WE_O <= (state_reg == ST_WAIT) && MEM_ACK_I && !store_reg;
            if (state_reg == ST_WAIT && MEM_ACK_I && !store_reg) begin
                RF_IDX_O   <= beat_reg;
                RF_WDATA_O <= ld_data;
            end
        end
    end

    // completion, fault and class reporting
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            REQ_READY_O    <= 1'b1;
            DONE_O         <= 1'b0;
            FAULT_O        <= 1'b0;
            FAULT_STATUS_O <= FAULT_NONE;
            ACC_CLASS_O    <= CLS_NONE;
        end else begin
            DONE_O  <= (state_reg == ST_WAIT) && MEM_ACK_I && last_beat;
            FAULT_O <= accept && fault_next;
            if (accept) begin
                ACC_CLASS_O    <= cls_next;
                FAULT_STATUS_O <= fault_next ? FAULT_ALIGN : FAULT_NONE;
            end
            // ready mirrors the state the sequencer enters next
            if (accept && !fault_next) begin
                REQ_READY_O <= 1'b0;
            end else if (state_reg == ST_WAIT && MEM_ACK_I && last_beat) begin
                REQ_READY_O <= 1'b1;
            end
        end
    end

endmodule

/* File: test/lsafmt_top_asserts.sv */
// checker: alignment, beat sequencing and fault relations at the top ports.
// assumes the single core clock and the async active-high reset.
module lsafmt_top_chk
    import lsafmt_pkg::*;
(
    input wire logic        REF_CLK_I,
    input wire logic        RESET_I,
    input wire logic        UNALIGN_EN_I,
    input wire logic        STRICT_ALIGN_I,
    input wire logic        REQ_VALID_I,
    input wire logic [2:0]  REQ_OP_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic        MEM_ACK_I,
    input wire logic        REQ_READY_O,
    input wire logic        MEM_REQ_O,
    input wire logic [31:0] MEM_ADDR_O,
    input wire logic        RF_WE_O,
    input wire logic        DONE_O,
    input wire logic        FAULT_O,
    input wire logic [3:0]  FAULT_STATUS_O,
    input wire logic [6:0]  ACC_CLASS_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    wire acc  = REQ_VALID_I && REQ_READY_O;  // request taken at this edge
    wire ackd = MEM_ACK_I && MEM_REQ_O;      // ack only counts on a held beat
    wire odd2 = REQ_ADDR_I[1:0] != 2'h0;     // not word aligned
    word_align_a: assert property (MEM_REQ_O |-> MEM_ADDR_O[1:0] == 2'h0)
        else $error("beat address not aligned");
    half_fault_a: assert property (acc && STRICT_ALIGN_I && REQ_OP_I == OP_HALF &&
        REQ_ADDR_I[0] |=> FAULT_O && FAULT_STATUS_O == FAULT_ALIGN) else $error("no half fault");
    block_fault_a: assert property (acc && STRICT_ALIGN_I && odd2 &&
        REQ_OP_I inside {OP_DOUBLE, OP_MULTI} |=> FAULT_O) else $error("no block fault");
    fault_quiet_a: assert property (FAULT_O |-> !MEM_REQ_O && !RF_WE_O)
        else $error("faulted access moved data");
    // a later word must follow one cycle after the gap, four bytes up
    next_word_a: assert property (ackd ##1 !DONE_O |=>
        MEM_REQ_O && MEM_ADDR_O == $past(MEM_ADDR_O, 2) + WORD_STEP) else $error("bad step");
    beat_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=>
        MEM_REQ_O && $stable(MEM_ADDR_O)) else $error("beat dropped early");
    done_ack_a: assert property (DONE_O |-> $past(ackd))
        else $error("done without ack");
    swap_class_a: assert property (acc && REQ_OP_I == OP_SWAP && UNALIGN_EN_I |=>
        ACC_CLASS_O == CLS_WEXCL) else $error("swap misclassed");
    cover property (FAULT_O);
    cover property (DONE_O && RF_WE_O);
    cover property (ackd ##2 MEM_REQ_O);
endmodule

bind lsafmt_top lsafmt_top_chk u_chk (.REF_CLK_I, .RESET_I, .UNALIGN_EN_I, .STRICT_ALIGN_I,
    .REQ_VALID_I, .REQ_OP_I, .REQ_ADDR_I, .MEM_ACK_I, .REQ_READY_O, .MEM_REQ_O, .MEM_ADDR_O,
    .RF_WE_O, .DONE_O, .FAULT_O, .FAULT_STATUS_O, .ACC_CLASS_O);

/* File: test/lsafmt_mem_model.sv */
// memory partner: 16 words, one-cycle ack, optional two-cycle stall.
// assumes each beat is held until its ack.
module lsafmt_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,   // stall before ack
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  be_i,
    output logic             ack_o,
    output logic      [31:0] rdata_o
);
    logic [31:0] mem [16];  // word storage, lane i = byte offset i
    logic [1:0]  wait_reg;  // stall counter
    wire go = req_i && !ack_o && wait_reg == {slow_i, 1'b0};
    // idle read lines flip each cycle so stale data never looks valid
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end else begin
            ack_o <= go;
            wait_reg <= (req_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
            rdata_o <= go ? mem[addr_i[5:2]] : ~rdata_o;
            for (int i = 0; i < 4; i++)
                if (go && we_i && be_i[i]) mem[addr_i[5:2]][8*i+:8] <= wdata_i[8*i+:8];
        end
endmodule

/* File: test/lsafmt_top_tb_top.sv */
// bench: formatter with the memory partner, scenario tasks judge results.
// assumes requests are offered only while idle.
module lsafmt_top_tb_top
    import lsafmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, be = 1'b0, ua = 1'b0, sa = 1'b0, wi = 1'b0, slow = 1'b0;
    logic vld = 1'b0, st = 1'b0, sg = 1'b0, flt, rfwe, done, fault, ack, mreq, mwe;
    logic [2:0]  op = 3'h0;
    logic [4:0]  cnt = 5'h0, sidx, nrf, ridx;
    logic [3:0]  mbe, fst;
    logic [6:0]  cls;
    logic [31:0] adr = 32'h0, src [4], rf [4], rfwd, rdata, madr, mwd;
    int          err_total = 0, n_tests = 0;
    initial forever #20 clk = ~clk;
    lsafmt_top u_lsafmt_top (.REF_CLK_I(clk), .RESET_I(rst), .DATA_BIG_END_I(be),
        .UNALIGN_EN_I(ua), .STRICT_ALIGN_I(sa), .WORD_INV_BE_I(wi), .REQ_VALID_I(vld),
        .REQ_OP_I(op), .REQ_STORE_I(st), .REQ_SIGNED_I(sg), .REQ_ADDR_I(adr),
        .REQ_COUNT_I(cnt), .SRC_DATA_I(src[sidx[1:0]]), .MEM_ACK_I(ack), .MEM_RDATA_I(rdata),
        .REQ_READY_O(), .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_ADDR_O(madr), .MEM_BE_O(mbe),
        .MEM_WDATA_O(mwd), .SRC_IDX_O(sidx), .RF_WE_O(rfwe), .RF_IDX_O(ridx), .RF_WDATA_O(rfwd),
        .DONE_O(done), .FAULT_O(fault), .FAULT_STATUS_O(fst), .ACC_CLASS_O(cls));
    lsafmt_mem_model u_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(mreq),
        .we_i(mwe), .addr_i(madr), .wdata_i(mwd), .be_i(mbe), .ack_o(ack), .rdata_o(rdata));
    task automatic tally_and_finish;
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer; collects load words, stops at done or fault, bounded
    task automatic xfer(input logic [2:0] o, input logic s, input logic [7:0] a,
                        input logic [4:0] n);
        int i;
        @(posedge clk);
        #1 {vld, op, st, adr, cnt} = {1'b1, o, s, 24'h0, a, n};
        @(posedge clk);
        #1 vld = 1'b0;
        nrf = 5'h0;
        for (i = 0; i < 99; i++) begin
            if (rfwe === 1'b1) begin
                rf[nrf[1:0]] = rfwd;
                chk({27'h0, ridx}, {27'h0, nrf});
                nrf++;
            end
            if (fault === 1'b1 || done === 1'b1) break;
            @(posedge clk);
            #1;
        end
        flt = fault;
        if (i == 99) begin
            err_total++;
            tally_and_finish;
        end
    endtask
    task automatic t_byte;
        src[0] = 32'h1122_b344;
        xfer(OP_WORD, 1'b1, 8'h04, 5'h0);
        chk(u_mem.mem[1], 32'h1122_b344);
        src[0] = 32'hcafe_00a5;
        xfer(OP_BYTE, 1'b1, 8'h06, 5'h0);
        chk(u_mem.mem[1], 32'h11a5_b344);
        sg = 1'b1;
        xfer(OP_BYTE, 1'b0, 8'h06, 5'h0);
        chk(rf[0], 32'hffff_ffa5);
        xfer(OP_HALF, 1'b0, 8'h04, 5'h0);
        chk(rf[0], 32'hffff_b344);
        sg = 1'b0;
        xfer(OP_BYTE, 1'b0, 8'h06, 5'h0);
        chk(rf[0], 32'h0000_00a5);
        xfer(OP_HALF, 1'b0, 8'h06, 5'h0);
        chk(rf[0], 32'h0000_11a5);
    endtask
    task automatic t_big;
        be = 1'b1;
        xfer(OP_HALF, 1'b0, 8'h04, 5'h0);
        chk(rf[0], 32'h0000_44b3);
        sg = 1'b1;
        xfer(OP_HALF, 1'b0, 8'h06, 5'h0);
        chk(rf[0], 32'hffff_a511);
        sg = 1'b0;
        xfer(OP_WORD, 1'b0, 8'h04, 5'h0);
        chk(rf[0], 32'h44b3_a511);
        src[0] = 32'h0102_beef;
        xfer(OP_HALF, 1'b1, 8'h08, 5'h0);
        xfer(OP_WORD, 1'b1, 8'h0c, 5'h0);
        chk(u_mem.mem[3], 32'hefbe_0201);
        be = 1'b0;
        xfer(OP_HALF, 1'b1, 8'h0a, 5'h0);
        chk(u_mem.mem[2], 32'hbeef_efbe);
        xfer(OP_WORD, 1'b0, 8'h05, 5'h0);
        chk(rf[0], 32'h4411_a5b3);
        wi = 1'b1;
        xfer(OP_BYTE, 1'b0, 8'h04, 5'h0);
        chk(rf[0], 32'h0000_0011);
        wi = 1'b0;
    endtask
    // stalled memory: unaligned multi store, then big-endian double load
    task automatic t_multi;
        slow = 1'b1;
        src = '{32'h0a0b_0c0d, 32'h1122_3344, 32'h5566_7788, 32'h0};
        xfer(OP_MULTI, 1'b1, 8'h13, 5'h3);
        chk(u_mem.mem[6], 32'h5566_7788);
        be = 1'b1;
        xfer(OP_DOUBLE, 1'b0, 8'h10, 5'h0);
        chk(rf[1], 32'h4433_2211);
        be = 1'b0;
        slow = 1'b0;
    endtask
    task automatic t_fault;
        sa = 1'b1;
        xfer(OP_HALF, 1'b1, 8'h09, 5'h0);
        chk({fst, 3'h0, flt}, {FAULT_ALIGN, 3'h0, 1'b1});
        xfer(OP_DOUBLE, 1'b1, 8'h16, 5'h0);
        chk({u_mem.mem[5][30:0], flt}, {31'h1122_3344, 1'b1});
        sa = 1'b0;
        ua = 1'b1;
        xfer(OP_SWAP, 1'b0, 8'h04, 5'h0);
        chk({cls, rf[0][24:0]}, {CLS_WEXCL, 25'h1a5_b344});
        ua = 1'b0;
        xfer(OP_SWAP, 1'b1, 8'h0c, 5'h0);
        chk({25'h0, cls}, {25'h0, CLS_SINGLE_WORD_STORE});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_byte;
        t_big;
        t_multi;
        t_fault;
        tally_and_finish;
    end
endmodule
